// *** src/card_link_pkg.sv ***
package card_link_pkg;
	// Widths
	localparam int ETU_DIV_W = 16;
	localparam int TMR_W = 18;
	// Reset-answer supervision, in initial etus
	localparam logic [17:0] GAP_MAX_ETUS = 18'd9600;
	localparam logic [17:0] ATR_MAX_ETUS = 18'd19200;
	// Time the reset line is held low before an answer is awaited
	localparam logic [17:0] RST_LOW_ETUS = 18'd400;
	// Character protocol timing, in etus
	localparam logic [17:0] TURN_ETUS = 18'd16;
	localparam logic [8:0] CHAR_GAP_MIN = 9'd12;
	localparam logic [9:0] WWT_UNIT = 10'd960;
	localparam logic [7:0] WI_DEFAULT = 8'h0a;
	localparam logic [7:0] NO_GUARD = 8'hff;
	localparam logic [7:0] GUARD_DEFAULT = 8'h00;
	// Procedure and status byte codes
	localparam logic [7:0] PROC_NULL = 8'h60;
	localparam logic [7:0] PROC_FETCH = 8'h61;
	localparam logic [7:0] PROC_RELEN = 8'h6c;
	localparam logic [3:0] SW_HI_A = 4'h6;
	localparam logic [3:0] SW_HI_B = 4'h9;
	// Response-fetch header class and instruction
	localparam logic [7:0] FETCH_CLA = 8'h00;
	localparam logic [7:0] FETCH_INS = 8'hc0;
	// Header length in bytes, last index
	localparam logic [2:0] HDR_LAST = 3'd4;
	// Protocol codes
	localparam logic [3:0] PROTO_CHAR = 4'h0;
	localparam logic [3:0] PROTO_BLOCK = 4'h1;

	// Command header
	typedef struct packed {
		logic [7:0] command_class;
		logic [7:0] instruction_code;
		logic [7:0] first_param;
		logic [7:0] second_param;
		logic [7:0] length_param;
	} hdr_s;

	// Status word handed to the application layer
	typedef struct packed {
		logic [7:0] first_status_byte;
		logic [7:0] second_status_byte;
	} status_s;

	// Terminal states
	typedef enum logic [3:0] {
		ST_IDLE, ST_RST_LOW, ST_ATR_TS, ST_ATR_T0, ST_ATR_IFACE, ST_ATR_HIST, ST_ATR_TCK,
		ST_ATR_NEXT, ST_READY, ST_HDR_TX, ST_WAIT_PROC, ST_XFER, ST_WAIT_XX, ST_WAIT_SW2,
		ST_DEACT
	} state_e;
endpackage : card_link_pkg

// *** src/etu_ticker.sv ***
`timescale 1ns/1ps
// Divides the system clock down to one enable pulse per etu
module etu_ticker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [card_link_pkg::ETU_DIV_W-1:0] div,
	output logic tick
);
	logic [card_link_pkg::ETU_DIV_W-1:0] cnt_r; // Cycles into the current etu

	// Count to the divisor, pulse and wrap
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			tick <= 1'b0;
		end else if (cnt_r + 1'b1 >= div) begin
			cnt_r <= '0;
			tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule : etu_ticker

// *** src/card_link_terminal.sv ***
// Notes on behaviour
// [RULE1] Reset-answer bytes from format char XOR to zero
// [RULE2] Card omits check byte for character-only answers
// [RULE3] Reject missing or wrong check byte otherwise
// [RULE4] Wrong check byte: deactivate within 4,800 etus
// [RULE5] Proceed after last byte; guard before transmitting
// [RULE6] Rejected cold answer: warm reset within 4,800
// [RULE7] Rejected warm answer: deactivate within 4,800
// [RULE8] Gap over 9,600 etus: deactivate
// [RULE9] Answer over 19,200 etus: deactivate
// [RULE10] Answer parity error: deactivate within 4,800
// [RULE11] No indicator byte means character protocol
// [RULE12] Own characters spaced 12 to 266 etus
// [RULE13] Card characters spaced at least 12 etus
// [RULE14] Work waiting time exceeded: deactivate
// [RULE15] Opposite-direction characters spaced 16 etus
// [RULE16] Send five-byte header, await procedure byte
// [RULE17] Card answers header with procedure or status
// [RULE18] Instruction echo sends all, complement one
// [RULE19] Null procedure byte extends waiting time
// [RULE20] Fetch and relength bytes resend header
// [RULE21] 6x/9x status: await second, hand both up
// [RULE22] Unlisted procedure byte: deactivate within 9,600
// [RULE23] Work wait integer defaults to ten
// [RULE24] Timeouts counted in etus from start edges
`timescale 1ns/1ps
module card_link_terminal (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [card_link_pkg::ETU_DIV_W-1:0] etu_div,
	input wire logic session_start,
	input wire logic rx_start,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_parity_err,
	input wire logic cmd_valid,
	input wire card_link_pkg::hdr_s cmd_hdr,
	input wire logic cmd_to_card,
	input wire logic app_data_valid,
	input wire logic [7:0] app_data,
	output logic card_rst_r,
	output logic deact_r,
	output logic tx_strobe_r,
	output logic [7:0] tx_data_r,
	output logic [3:0] protocol_r,
	output logic cmd_ready_r,
	output logic data_req_r,
	output logic rd_strobe_r,
	output logic [7:0] rd_data_r,
	output logic sw_valid_r,
	output card_link_pkg::status_s sw_r
);
	logic rst_sync1_r, rst_n_r; // Reset release synchroniser
	logic etu_tick; // One pulse per etu
	card_link_pkg::state_e state_r; // Terminal state
	logic [17:0] since_rx_r; // Etus since last card start edge
	logic [17:0] since_tx_r; // Etus since own last start edge
	logic [17:0] since_any_r; // Etus since any start edge
	logic [17:0] since_ts_r; // Etus since sync char start edge
	logic tmr_clr_r; // Restarts the own-side timer for reset timing
	logic warm_r; // Current answer follows a warm reset
	logic [7:0] xor_r; // Running check over the answer
	logic [3:0] mask_r; // Interface bytes still due in this group
	logic [3:0] hist_r; // Historical bytes still due
	logic [2:0] grp_r; // Interface group number
	logic tck_need_r; // Check byte expected
	logic bad_r; // Answer already rejected on content
	logic [7:0] guard_n_r; // Extra guard from the extra guard char
	logic [7:0] wi_r; // Work wait integer
	card_link_pkg::hdr_s hdr_r; // Header being sent
	logic [2:0] hdr_idx_r; // Header byte index
	logic to_card_r; // Data direction of current command
	logic [8:0] remain_r; // Data bytes left in command
	logic [8:0] xfer_r; // Data bytes released by last procedure byte
	logic fetch_r; // Second byte belongs to a fetch request
	logic [8:0] char_gap; // Own character spacing
	logic [17:0] wwt; // Work waiting time in etus
	logic can_tx; // Spacing allows a new own character
	logic [7:0] hdr_byte; // Header byte at current index

	// Release reset through two flip-flops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_sync1_r <= 1'b1;
			rst_n_r <= rst_sync1_r;
		end
	end

	etu_ticker etu_ticker_inst (
		.clk(clk),
		.rst_n(rst_n_r),
		.div(etu_div),
		.tick(etu_tick)
	);

	// Saturating etu count
	function automatic logic [17:0] inc_sat(input logic [17:0] v, input logic en);
		inc_sat = (en && v != '1) ? v + 18'd1 : v;
	endfunction : inc_sat

	// Spacing and waiting limits
	always_comb begin
		char_gap = (guard_n_r == card_link_pkg::NO_GUARD) ? card_link_pkg::CHAR_GAP_MIN :
			card_link_pkg::CHAR_GAP_MIN + {1'b0, guard_n_r}; // [RULE12]
		wwt = 18'(card_link_pkg::WWT_UNIT) * 18'(wi_r); // [RULE14] [RULE23]
		can_tx = (since_rx_r >= card_link_pkg::TURN_ETUS) && // [RULE15] [RULE5]
			(since_tx_r >= {9'd0, char_gap}); // [RULE12]
		unique case (hdr_idx_r)
			3'd0: hdr_byte = hdr_r.command_class;
			3'd1: hdr_byte = hdr_r.instruction_code;
			3'd2: hdr_byte = hdr_r.first_param;
			3'd3: hdr_byte = hdr_r.second_param;
			default: hdr_byte = hdr_r.length_param;
		endcase
	end

	// Etu timers restarted by start edges
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			since_rx_r <= '1;
			since_tx_r <= '1;
			since_any_r <= '1;
			since_ts_r <= '0;
		end else begin
			since_rx_r <= rx_start ? 18'd0 : inc_sat(since_rx_r, etu_tick); // [RULE24]
			since_tx_r <= (tx_strobe_r || tmr_clr_r) ? 18'd0 : inc_sat(since_tx_r, etu_tick);
			since_any_r <= (rx_start || tx_strobe_r) ? 18'd0 : inc_sat(since_any_r, etu_tick);
			if (rx_start && state_r == card_link_pkg::ST_ATR_TS)
				since_ts_r <= '0;
			else
				since_ts_r <= inc_sat(since_ts_r, etu_tick);
		end
	end

	// Main sequencer: reset answer, then character protocol
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			state_r <= card_link_pkg::ST_IDLE;
			card_rst_r <= 1'b0;
			deact_r <= 1'b0;
			tx_strobe_r <= 1'b0;
			tx_data_r <= '0;
			tmr_clr_r <= 1'b0;
			warm_r <= 1'b0;
			xor_r <= '0;
			mask_r <= '0;
			hist_r <= '0;
			grp_r <= '0;
			tck_need_r <= 1'b0;
			bad_r <= 1'b0;
			guard_n_r <= card_link_pkg::GUARD_DEFAULT;
			wi_r <= card_link_pkg::WI_DEFAULT;
			protocol_r <= card_link_pkg::PROTO_CHAR;
			hdr_r <= '0;
			hdr_idx_r <= '0;
			to_card_r <= 1'b0;
			remain_r <= '0;
			xfer_r <= '0;
			fetch_r <= 1'b0;
			rd_strobe_r <= 1'b0;
			rd_data_r <= '0;
			sw_valid_r <= 1'b0;
			sw_r <= '0;
		end else begin
			tx_strobe_r <= 1'b0;
			tmr_clr_r <= 1'b0;
			rd_strobe_r <= 1'b0;
			sw_valid_r <= 1'b0;
			unique case (state_r)
				// Wait for the session to be opened
				card_link_pkg::ST_IDLE, card_link_pkg::ST_DEACT: begin
					if (session_start) begin
						deact_r <= 1'b0;
						warm_r <= 1'b0;
						card_rst_r <= 1'b0;
						tmr_clr_r <= 1'b1;
						state_r <= card_link_pkg::ST_RST_LOW;
					end
				end
				// Hold the reset line low, then await the answer
				card_link_pkg::ST_RST_LOW: begin
					if (!tmr_clr_r && since_tx_r >= card_link_pkg::RST_LOW_ETUS) begin
						card_rst_r <= 1'b1;
						xor_r <= '0;
						bad_r <= 1'b0;
						tck_need_r <= 1'b0;
						guard_n_r <= card_link_pkg::GUARD_DEFAULT;
						wi_r <= card_link_pkg::WI_DEFAULT; // [RULE23]
						protocol_r <= card_link_pkg::PROTO_CHAR; // [RULE11]
						state_r <= card_link_pkg::ST_ATR_TS;
					end
				end
				card_link_pkg::ST_ATR_TS: begin
					if (rx_valid)
						state_r <= rx_parity_err ? card_link_pkg::ST_DEACT : // [RULE10]
							card_link_pkg::ST_ATR_T0;
				end
				// Format char opens the first group
				card_link_pkg::ST_ATR_T0: begin
					if (rx_valid) begin
						xor_r <= rx_data; // [RULE1]
						mask_r <= rx_data[7:4];
						hist_r <= rx_data[3:0];
						grp_r <= 3'd1;
						state_r <= card_link_pkg::ST_ATR_NEXT;
					end
				end
				// Interface bytes, lowest pending first
				card_link_pkg::ST_ATR_IFACE: begin
					if (rx_valid) begin
						xor_r <= xor_r ^ rx_data; // [RULE1]
						state_r <= card_link_pkg::ST_ATR_NEXT;
						if (mask_r[0]) begin
							mask_r[0] <= 1'b0;
						end else if (mask_r[1]) begin
							mask_r[1] <= 1'b0;
						end else if (mask_r[2]) begin
							mask_r[2] <= 1'b0;
							if (grp_r == 3'd1)
								guard_n_r <= rx_data;
							if (grp_r == 3'd2) begin
								wi_r <= rx_data;
								if (rx_data == 8'h00)
									bad_r <= 1'b1;
							end
						end else begin
							mask_r <= rx_data[7:4];
							grp_r <= grp_r + 3'd1;
							if (rx_data[3:0] != card_link_pkg::PROTO_CHAR)
								tck_need_r <= 1'b1; // [RULE2]
							if (grp_r == 3'd1) begin
								protocol_r <= rx_data[3:0]; // [RULE11]
								if (rx_data[3:0] > card_link_pkg::PROTO_BLOCK)
									bad_r <= 1'b1;
							end
						end
					end
				end
				card_link_pkg::ST_ATR_HIST: begin
					if (rx_valid) begin
						xor_r <= xor_r ^ rx_data; // [RULE1]
						hist_r <= hist_r - 4'd1;
						state_r <= card_link_pkg::ST_ATR_NEXT;
					end
				end
				// Check byte: wrong value deactivates at once
				card_link_pkg::ST_ATR_TCK: begin
					if (rx_valid) begin
						tck_need_r <= 1'b0;
						if ((xor_r ^ rx_data) != 8'h00)
							state_r <= card_link_pkg::ST_DEACT; // [RULE3] [RULE4]
						else
							state_r <= card_link_pkg::ST_ATR_NEXT;
					end
				end
				// Decide what the answer still owes
				card_link_pkg::ST_ATR_NEXT: begin
					if (mask_r != 4'd0)
						state_r <= card_link_pkg::ST_ATR_IFACE;
					else if (hist_r != 4'd0)
						state_r <= card_link_pkg::ST_ATR_HIST;
					else if (tck_need_r)
						state_r <= card_link_pkg::ST_ATR_TCK;
					else if (bad_r && !warm_r) begin
						warm_r <= 1'b1; // [RULE6]
						card_rst_r <= 1'b0;
						tmr_clr_r <= 1'b1;
						state_r <= card_link_pkg::ST_RST_LOW;
					end else if (bad_r)
						state_r <= card_link_pkg::ST_DEACT; // [RULE7]
					else
						state_r <= card_link_pkg::ST_READY; // [RULE5]
				end
				// Accept a command header
				card_link_pkg::ST_READY: begin
					if (cmd_valid && protocol_r == card_link_pkg::PROTO_CHAR) begin
						hdr_r <= cmd_hdr;
						to_card_r <= cmd_to_card;
						hdr_idx_r <= '0;
						remain_r <= (!cmd_to_card && cmd_hdr.length_param == 8'h00) ?
							9'h100 : {1'b0, cmd_hdr.length_param};
						state_r <= card_link_pkg::ST_HDR_TX;
					end
				end
				// Five header bytes, each when spacing allows
				card_link_pkg::ST_HDR_TX: begin
					if (can_tx && !tx_strobe_r) begin
						tx_strobe_r <= 1'b1; // [RULE16]
						tx_data_r <= hdr_byte;
						hdr_idx_r <= hdr_idx_r + 3'd1;
						if (hdr_idx_r == card_link_pkg::HDR_LAST)
							state_r <= card_link_pkg::ST_WAIT_PROC; // [RULE16]
					end
				end
				// Decode procedure or first status byte
				card_link_pkg::ST_WAIT_PROC: begin
					if (rx_valid) begin
						if (rx_data == hdr_r.instruction_code) begin
							xfer_r <= remain_r; // [RULE18]
							state_r <= card_link_pkg::ST_XFER;
						end else if (rx_data == ~hdr_r.instruction_code) begin
							xfer_r <= (remain_r != 9'd0) ? 9'd1 : 9'd0; // [RULE18]
							state_r <= card_link_pkg::ST_XFER;
						end else if (rx_data == card_link_pkg::PROC_NULL) begin
							state_r <= card_link_pkg::ST_WAIT_PROC; // [RULE19]
						end else if (rx_data == card_link_pkg::PROC_FETCH ||
							rx_data == card_link_pkg::PROC_RELEN) begin
							fetch_r <= (rx_data == card_link_pkg::PROC_FETCH); // [RULE20]
							state_r <= card_link_pkg::ST_WAIT_XX;
						end else if (rx_data[7:4] == card_link_pkg::SW_HI_A ||
							rx_data[7:4] == card_link_pkg::SW_HI_B) begin
							sw_r.first_status_byte <= rx_data; // [RULE21]
							state_r <= card_link_pkg::ST_WAIT_SW2;
						end else begin
							state_r <= card_link_pkg::ST_DEACT; // [RULE22]
						end
					end else if (since_any_r > wwt) begin
						state_r <= card_link_pkg::ST_DEACT; // [RULE14]
					end
				end
				// Move the released data bytes
				card_link_pkg::ST_XFER: begin
					if (xfer_r == 9'd0) begin
						state_r <= card_link_pkg::ST_WAIT_PROC; // [RULE18]
					end else if (to_card_r) begin
						if (data_req_r && app_data_valid && can_tx && !tx_strobe_r) begin
							tx_strobe_r <= 1'b1;
							tx_data_r <= app_data;
							xfer_r <= xfer_r - 9'd1;
							remain_r <= remain_r - 9'd1;
						end
					end else if (rx_valid) begin
						rd_strobe_r <= 1'b1;
						rd_data_r <= rx_data;
						xfer_r <= xfer_r - 9'd1;
						remain_r <= remain_r - 9'd1;
					end else if (since_any_r > wwt) begin
						state_r <= card_link_pkg::ST_DEACT; // [RULE14]
					end
				end
				// Second procedure byte gives the new length
				card_link_pkg::ST_WAIT_XX: begin
					if (rx_valid) begin
						if (fetch_r) begin
							hdr_r <= {card_link_pkg::FETCH_CLA, card_link_pkg::FETCH_INS,
								8'h00, 8'h00, rx_data}; // [RULE20]
							to_card_r <= 1'b0;
						end else begin
							hdr_r.length_param <= rx_data; // [RULE20]
						end
						remain_r <= (rx_data == 8'h00 && (fetch_r || !to_card_r)) ?
							9'h100 : {1'b0, rx_data};
						hdr_idx_r <= '0;
						state_r <= card_link_pkg::ST_HDR_TX;
					end else if (since_any_r > wwt) begin
						state_r <= card_link_pkg::ST_DEACT; // [RULE14]
					end
				end
				// Second status byte completes the command
				card_link_pkg::ST_WAIT_SW2: begin
					if (rx_valid) begin
						sw_r.second_status_byte <= rx_data;
						sw_valid_r <= 1'b1; // [RULE21]
						state_r <= card_link_pkg::ST_READY;
					end else if (since_any_r > wwt) begin
						state_r <= card_link_pkg::ST_DEACT; // [RULE14]
					end
				end
			endcase
			// Answer supervision overrides content decoding
			if (state_r inside {card_link_pkg::ST_ATR_T0, card_link_pkg::ST_ATR_IFACE,
				card_link_pkg::ST_ATR_HIST, card_link_pkg::ST_ATR_TCK,
				card_link_pkg::ST_ATR_NEXT}) begin
				if (rx_valid && rx_parity_err)
					state_r <= card_link_pkg::ST_DEACT; // [RULE10]
				else if (since_rx_r > card_link_pkg::GAP_MAX_ETUS)
					state_r <= card_link_pkg::ST_DEACT; // [RULE8]
				else if (since_ts_r > card_link_pkg::ATR_MAX_ETUS)
					state_r <= card_link_pkg::ST_DEACT; // [RULE9]
			end
			// Deactivation drops reset and flags the session closed
			if (state_r == card_link_pkg::ST_DEACT && !session_start) begin
				deact_r <= 1'b1; // [RULE4] [RULE7]
				card_rst_r <= 1'b0;
			end
		end
	end

	// Command-ready and data-request handshake levels
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			cmd_ready_r <= 1'b0;
			data_req_r <= 1'b0;
		end else begin
			cmd_ready_r <= (state_r == card_link_pkg::ST_READY) && !cmd_valid &&
				protocol_r == card_link_pkg::PROTO_CHAR;
			// Request only when spacing allows; drop at once when a byte is taken
			data_req_r <= (state_r == card_link_pkg::ST_XFER) && to_card_r &&
				xfer_r != 9'd0 && can_tx && !tx_strobe_r && !(data_req_r && app_data_valid);
		end
	end
endmodule : card_link_terminal

// *** tb/card_link_terminal_asserts.sv ***
`timescale 1ns/1ps
// Pin-level timing and coding checks on the terminal
module card_link_terminal_asserts (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [card_link_pkg::ETU_DIV_W-1:0] etu_div,
	input wire logic rx_start,
	input wire logic tx_strobe_r,
	input wire logic card_rst_r,
	input wire logic [3:0] protocol_r,
	input wire logic cmd_ready_r,
	input wire logic sw_valid_r,
	input wire card_link_pkg::status_s sw_r
);
	int since_tx; // Clocks since our own last start edge
	int since_rx; // Clocks since the card's last start edge
	int low_cnt; // Clocks the card reset line has been low
	int e; // Clocks per etu
	assign e = int'(etu_div);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// Distance from our last character, saturating
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			since_tx <= 1000000;
		end else begin
			since_tx <= tx_strobe_r ? 0 : (since_tx > 1000000 ? since_tx : since_tx + 1);
		end
	end
	// Distance from the card's last character, saturating
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			since_rx <= 1000000;
		end else begin
			since_rx <= rx_start ? 0 : (since_rx > 1000000 ? since_rx : since_rx + 1);
		end
	end
	// Length of the current low phase of the card reset line
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			low_cnt <= 0;
		end else begin
			low_cnt <= card_rst_r ? 0 : (low_cnt > 1000000 ? low_cnt : low_cnt + 1);
		end
	end
	property p_tx_pulse;
		tx_strobe_r |=> !tx_strobe_r;
	endproperty
	a_tx_pulse: assert property (p_tx_pulse) else $error("Character strobe too long");
	property p_tx_gap;
		tx_strobe_r |-> since_tx + e >= 12 * e;
	endproperty
	a_tx_gap: assert property (p_tx_gap) else $error("Own characters too close");
	property p_turn;
		tx_strobe_r |-> since_rx + e >= 16 * e;
	endproperty
	a_turn: assert property (p_turn) else $error("Turnaround gap too short");
	property p_sw_code;
		sw_valid_r |-> sw_r.first_status_byte[7:4] inside {4'h6, 4'h9}
			&& !(sw_r.first_status_byte inside {8'h60, 8'h61, 8'h6c});
	endproperty
	a_sw_code: assert property (p_sw_code) else $error("Bad first status byte");
	property p_sw_pulse;
		sw_valid_r |=> !sw_valid_r;
	endproperty
	a_sw_pulse: assert property (p_sw_pulse) else $error("Status strobe too long");
	property p_proto;
		cmd_ready_r |-> protocol_r inside {4'h0, 4'h1};
	endproperty
	a_proto: assert property (p_proto) else $error("Unknown protocol in use");
	property p_rst_low;
		$rose(card_rst_r) |-> low_cnt + e >= 400 * e;
	endproperty
	a_rst_low: assert property (p_rst_low) else $error("Reset pulse too short");
	property p_quiet;
		!card_rst_r |-> !tx_strobe_r && !cmd_ready_r;
	endproperty
	a_quiet: assert property (p_quiet) else $error("Activity while card in reset");
endmodule : card_link_terminal_asserts

bind card_link_terminal card_link_terminal_asserts card_link_terminal_asserts_inst (
	.clk(clk),
	.reset_n(reset_n),
	.etu_div(etu_div),
	.rx_start(rx_start),
	.tx_strobe_r(tx_strobe_r),
	.card_rst_r(card_rst_r),
	.protocol_r(protocol_r),
	.cmd_ready_r(cmd_ready_r),
	.sw_valid_r(sw_valid_r),
	.sw_r(sw_r)
);

// *** tb/card_model.sv ***
`timescale 1ns/1ps
// Behavioural card: sends characters on request with legal spacing
module card_model #(
	parameter int ETU = 4
) (
	input wire logic clk,
	input wire logic tx_strobe_r,
	output logic rx_start,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_parity_err
);
	int quiet = 0; // Clocks since the last start edge from either side
	initial begin
		rx_start = 1'b0;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_parity_err = 1'b0;
	end
	// Track line silence in both directions
	always @(posedge clk) begin
		quiet <= (tx_strobe_r === 1'b1 || rx_start) ? 0 : quiet + 1;
	end
	// One character: start edge, then the byte ten etus later
	task automatic send(input logic [7:0] b, input logic perr = 1'b0);
		while (quiet < 20 * ETU) @(posedge clk);
		rx_start <= 1'b1;
		@(posedge clk);
		rx_start <= 1'b0;
		repeat (10 * ETU) @(posedge clk);
		rx_valid <= 1'b1;
		rx_data <= b;
		rx_parity_err <= perr;
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_data <= ~b;
		rx_parity_err <= 1'b0;
	endtask : send
endmodule : card_model

// *** tb/card_link_terminal_test.sv ***
`timescale 1ns/1ps
module card_link_terminal_test;
	localparam int ETU = 4; // Clocks per etu, kept short
	logic clk;
	logic reset_n;
	logic session_start;
	logic cmd_valid;
	card_link_pkg::hdr_s cmd_hdr;
	logic cmd_to_card;
	logic app_data_valid = 1'b0;
	logic [7:0] app_data;
	logic [7:0] fed = 8'h00; // Data bytes handed over so far
	logic [15:0] etu_div = 16'(ETU); // Clocks per etu seen by the block
	logic rx_start;
	logic rx_valid;
	logic [7:0] rx_data;
	logic rx_parity_err;
	logic card_rst_r;
	logic deact_r;
	logic tx_strobe_r;
	logic [7:0] tx_data_r;
	logic [3:0] protocol_r;
	logic cmd_ready_r;
	logic data_req_r;
	logic rd_strobe_r;
	logic [7:0] rd_data_r;
	logic sw_valid_r;
	card_link_pkg::status_s sw_r;
	int error_cnt = 0;
	int total_checks = 0;
	logic [7:0] tx_q[$]; // Bytes sent to the card
	logic [15:0] sw_q[$]; // Status words handed up
	logic [7:0] rd_q[$]; // Data bytes read from the card
	card_link_terminal card_link_terminal_inst (.clk(clk), .reset_n(reset_n),
		.etu_div(etu_div), .session_start(session_start), .rx_start(rx_start),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_parity_err(rx_parity_err),
		.cmd_valid(cmd_valid), .cmd_hdr(cmd_hdr), .cmd_to_card(cmd_to_card),
		.app_data_valid(app_data_valid), .app_data(app_data), .card_rst_r(card_rst_r),
		.deact_r(deact_r), .tx_strobe_r(tx_strobe_r), .tx_data_r(tx_data_r),
		.protocol_r(protocol_r), .cmd_ready_r(cmd_ready_r), .data_req_r(data_req_r),
		.rd_strobe_r(rd_strobe_r), .rd_data_r(rd_data_r), .sw_valid_r(sw_valid_r), .sw_r(sw_r));
	card_model #(.ETU(ETU)) card_model_inst (.clk(clk), .tx_strobe_r(tx_strobe_r),
		.rx_start(rx_start), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_parity_err(rx_parity_err));
	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Data source: one byte per request, counting up from 30
	assign app_data = 8'h2f + fed;
	always @(posedge clk) begin
		app_data_valid <= data_req_r === 1'b1 && !app_data_valid;
		if (data_req_r === 1'b1 && !app_data_valid) fed <= fed + 8'h01;
	end
	// Collect everything the terminal emits
	always @(posedge clk) begin
		if (tx_strobe_r === 1'b1) tx_q.push_back(tx_data_r);
		if (sw_valid_r === 1'b1) sw_q.push_back(sw_r);
		if (rd_strobe_r === 1'b1) rd_q.push_back(rd_data_r);
	end
	task chk(input logic [39:0] got, input logic [39:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task results();
		if (error_cnt == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : results
	// Bounded wait: 0 ready, 1 n bytes sent, 2 n status words, 3 reset line high
	task wait_until(input int which, input int n, output int t);
		for (t = 0; t < 40000; t++) begin
			if ((which == 0 && cmd_ready_r === 1'b1) || (which == 1 && tx_q.size() >= n)
				|| (which == 2 && sw_q.size() >= n) || (which == 3 && card_rst_r === 1'b1)) return;
			@(posedge clk);
		end
		error_cnt++;
		$display("[FAIL] %0t wait %0d timed out", $time, which);
		results();
	endtask : wait_until
	// Open a session and time the reset pulse
	task session();
		int t;
		session_start <= 1'b1;
		@(posedge clk);
		session_start <= 1'b0;
		wait_until(3, 0, t);
		chk(40'((t + 2 * ETU) / (20 * ETU)), 40'd20);
	endtask : session
	task command(input logic [39:0] h, input logic dir);
		int t;
		wait_until(0, 0, t);
		cmd_hdr <= h;
		cmd_to_card <= dir;
		cmd_valid <= 1'b1;
		@(posedge clk);
		cmd_valid <= 1'b0;
	endtask : command
	// Five header bytes in order
	task exp_hdr(input logic [39:0] h);
		int t;
		wait_until(1, 5, t);
		for (int k = 0; k < 5; k++) chk(40'(tx_q[k]), 40'(h[39 - 8 * k -: 8]));
		tx_q.delete();
	endtask : exp_hdr
	// Wrong check byte on a block-protocol answer leaves no command slot
	task scen_bad_tck();
		session();
		card_model_inst.send(8'h3b);
		card_model_inst.send(8'h80);
		card_model_inst.send(8'h01);
		card_model_inst.send(8'h55);
		repeat (100 * ETU) @(posedge clk);
		chk(40'(cmd_ready_r), 40'd0);
		chk(40'(deact_r), 40'd1);
	endtask : scen_bad_tck
	// Character-only answer without check byte is accepted
	task scen_atr_ok();
		int t;
		session();
		card_model_inst.send(8'h3b);
		card_model_inst.send(8'h00);
		wait_until(0, 0, t);
		chk(40'(protocol_r), 40'd0);
	endtask : scen_atr_ok
	// Write: complement sends one byte, echo sends the rest
	task scen_write();
		int t;
		command(40'h00a4040002, 1'b1);
		exp_hdr(40'h00a4040002);
		card_model_inst.send(8'h5b);
		wait_until(1, 1, t);
		card_model_inst.send(8'ha4);
		wait_until(1, 2, t);
		chk(40'({tx_q[0], tx_q[1]}), 40'h3031);
		card_model_inst.send(8'h90);
		card_model_inst.send(8'h00);
		wait_until(2, 1, t);
		chk(40'(sw_q[0]), 40'h9000);
		tx_q.delete();
		sw_q.delete();
	endtask : scen_write
	// Read: null byte, relength, fetch, data, status
	task scen_read();
		int t;
		command(40'h00b2010c00, 1'b0);
		exp_hdr(40'h00b2010c00);
		card_model_inst.send(8'h60);
		card_model_inst.send(8'h6c);
		card_model_inst.send(8'h04);
		exp_hdr(40'h00b2010c04);
		card_model_inst.send(8'h61);
		card_model_inst.send(8'h01);
		exp_hdr(40'h00c0000001);
		card_model_inst.send(8'hc0);
		card_model_inst.send(8'h5a);
		card_model_inst.send(8'h6a);
		card_model_inst.send(8'h82);
		wait_until(2, 1, t);
		chk(40'(rd_q.size() > 0 ? rd_q[0] : 8'h00), 40'h5a);
		chk(40'(sw_q[0]), 40'h6a82);
	endtask : scen_read
	// Unlisted procedure byte ends the session
	task scen_bad_proc();
		command(40'h80ca9f1704, 1'b0);
		exp_hdr(40'h80ca9f1704);
		card_model_inst.send(8'h20);
		repeat (200 * ETU) @(posedge clk);
		chk(40'(cmd_ready_r), 40'd0);
		chk(40'(deact_r), 40'd1);
	endtask : scen_bad_proc
	// Parity error in the answer ends the session
	task scen_parity();
		session();
		card_model_inst.send(8'h3b);
		card_model_inst.send(8'h00, 1'b1);
		repeat (100 * ETU) @(posedge clk);
		chk(40'({deact_r, cmd_ready_r}), 40'h2);
	endtask : scen_parity
	// Main sequence
	initial begin
		reset_n = 1'b0;
		session_start = 1'b0;
		cmd_valid = 1'b0;
		cmd_hdr = 40'h0000000000;
		cmd_to_card = 1'b0;
		repeat (3) @(posedge clk);
		chk(40'({card_rst_r, cmd_ready_r, tx_strobe_r, sw_valid_r}), 40'd0);
		reset_n <= 1'b1;
		repeat (5) @(posedge clk);
		scen_bad_tck();
		scen_atr_ok();
		scen_write();
		scen_read();
		scen_bad_proc();
		scen_parity();
		results();
	end
endmodule : card_link_terminal_test
